// *** include/charger_timer_pkg.sv ***
// Register map, field layout, reset values and timer figures for the timer control bank
package charger_timer_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFS_OTG = 8'h0D;
  localparam logic [7:0] OFS_TIMER = 8'h0E;
  localparam logic [7:0] OFS_CTRL = 8'h0F;
  localparam logic [7:0] RST_OTG = 8'h4B;
  localparam logic [7:0] RST_TIMER = 8'h3D;
  localparam logic [7:0] RST_CTRL = 8'hA2;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // Offset and otg_limit_and_precharge_timer fields
  localparam int OTG_PRE_BIT = 7;
  localparam int OTG_LIM_MSB = 6;
  localparam int OTG_LIM_W = 7;
  localparam logic [6:0] OTG_LIM_MIN = 7'h04;
  localparam int OTG_STEP_MA = 40;
  localparam int OTG_MA_W = 13;
  // safety_timer_control fields
  localparam int TOP_MSB = 7;
  localparam int TOP_LSB = 6;
  localparam int TRI_EN_BIT = 5;
  localparam int PRE_EN_BIT = 4;
  localparam int FAST_EN_BIT = 3;
  localparam int FAST_MSB = 2;
  localparam int FAST_LSB = 1;
  localparam int HALF_BIT = 0;
  // charge_main_control fields
  localparam int AUTO_DIS_BIT = 7;
  localparam int FORCE_DIS_BIT = 6;
  localparam int CHG_EN_BIT = 5;
  localparam int OPT_EN_BIT = 4;
  localparam int OPT_FORCE_BIT = 3;
  localparam int HIZ_BIT = 2;
  localparam int TERM_BIT = 1;
  // Timer durations in minutes
  localparam int MIN_W = 11;
  localparam logic [10:0] PRE_LONG_MIN = 11'h078;
  localparam logic [10:0] PRE_SHORT_MIN = 11'h01E;
  localparam logic [10:0] TRICKLE_MIN = 11'h03C;
  localparam logic [10:0] TOP_OFF_MIN = 11'h000;
  localparam logic [10:0] TOP_15_MIN = 11'h00F;
  localparam logic [10:0] TOP_30_MIN = 11'h01E;
  localparam logic [10:0] TOP_45_MIN = 11'h02D;
  localparam logic [10:0] FAST_5H_MIN = 11'h12C;
  localparam logic [10:0] FAST_8H_MIN = 11'h1E0;
  localparam logic [10:0] FAST_12H_MIN = 11'h2D0;
  localparam logic [10:0] FAST_24H_MIN = 11'h5A0;
  localparam int SYNC_W = 4;
  localparam int SY_ADAPTER = 0;
  localparam int SY_DPM = 1;
  localparam int SY_THERMAL = 2;
  localparam int SY_OVP = 3;
endpackage : charger_timer_pkg

// *** logic/charger_timer_control_regs.sv ***
// Timer, OTG limit and charger control register bank of the battery charger
`timescale 1ns/1ps

module charger_timer_control_regs
  import charger_timer_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] rdata,
  input wire logic reg_reset_req,
  input wire logic watchdog_expired,
  input wire logic optimizer_started,
  input wire logic adapter_plug_pin,
  input wire logic dpm_pin,
  input wire logic thermal_reg_pin,
  input wire logic battery_ovp_pin,
  output logic [OTG_MA_W-1:0] otg_limit_ma,
  output logic [MIN_W-1:0] precharge_minutes,
  output logic [MIN_W-1:0] trickle_minutes,
  output logic [MIN_W-1:0] topoff_minutes,
  output logic [MIN_W-1:0] fast_minutes,
  output logic topoff_active,
  output logic trickle_run,
  output logic precharge_run,
  output logic fast_run,
  output logic timer_half_rate,
  output logic timer_reset,
  output logic discharge_on,
  output logic charge_on,
  output logic term_allowed,
  output logic hiz_on,
  output logic optimizer_on,
  output logic optimizer_run_req
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function automatic logic [OTG_LIM_W-1:0] clamp_limit(input logic [OTG_LIM_W-1:0] code);
    clamp_limit = (code < OTG_LIM_MIN) ? OTG_LIM_MIN : code;
  endfunction : clamp_limit

  function automatic logic [MIN_W-1:0] topoff_decode(input logic [1:0] code);
    unique case (code)
      2'h0: topoff_decode = TOP_OFF_MIN;
      2'h1: topoff_decode = TOP_15_MIN;
      2'h2: topoff_decode = TOP_30_MIN;
      2'h3: topoff_decode = TOP_45_MIN;
    endcase
  endfunction : topoff_decode

  function automatic logic [MIN_W-1:0] fast_decode(input logic [1:0] code);
    unique case (code)
      2'h0: fast_decode = FAST_5H_MIN;
      2'h1: fast_decode = FAST_8H_MIN;
      2'h2: fast_decode = FAST_12H_MIN;
      2'h3: fast_decode = FAST_24H_MIN;
    endcase
  endfunction : fast_decode

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [SYNC_W-1:0] sync3_q;
  logic [SYNC_W-1:0] pins_q;
  logic [SYNC_W-1:0] pins_d;
  logic adapter_prev_q;
  logic adapter_plug;

  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else if (clk_en) begin
      sync1_q <= {battery_ovp_pin, thermal_reg_pin, dpm_pin, adapter_plug_pin};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Accept a change once the two later stages agree
  always_comb begin
    for (int i = 0; i < SYNC_W; i++) begin
      pins_d[i] = (sync2_q[i] == sync3_q[i]) ? sync3_q[i] : pins_q[i];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pins_q <= '0;
      adapter_prev_q <= 1'b0;
    end else if (clk_en) begin
      pins_q <= pins_d;
      adapter_prev_q <= pins_q[SY_ADAPTER];
    end
  end

  assign adapter_plug = pins_q[SY_ADAPTER] & ~adapter_prev_q;

  // ----------------------------------------
  // Register fields
  // ----------------------------------------
  logic pre_sel_q;
  logic [OTG_LIM_W-1:0] otg_lim_q;
  logic [1:0] top_sel_q;
  logic tri_en_q;
  logic pre_en_q;
  logic fast_en_q;
  logic [1:0] fast_sel_q;
  logic half_en_q;
  logic auto_dis_q;
  logic force_dis_q;
  logic chg_en_q;
  logic opt_en_q;
  logic opt_force_q;
  logic hiz_q;
  logic term_q;
  logic wr_otg;
  logic wr_timer;
  logic wr_ctrl;
  logic wd_hit;

  assign wr_otg = wr_en && (addr == OFS_OTG);
  assign wr_timer = wr_en && (addr == OFS_TIMER);
  assign wr_ctrl = wr_en && (addr == OFS_CTRL);
  assign wd_hit = watchdog_expired && !reg_reset_req;

  // Watchdog-reset fields of the OTG and timer registers
  always_ff @(posedge clock) begin
    if (rst) begin
      pre_sel_q <= RST_OTG[OTG_PRE_BIT];
      otg_lim_q <= RST_OTG[OTG_LIM_MSB:0];
      {top_sel_q, tri_en_q, pre_en_q, fast_en_q, fast_sel_q, half_en_q} <= RST_TIMER;
    end else if (clk_en) begin
      if (reg_reset_req || watchdog_expired) begin
        pre_sel_q <= RST_OTG[OTG_PRE_BIT];
        otg_lim_q <= RST_OTG[OTG_LIM_MSB:0];
        {top_sel_q, tri_en_q, pre_en_q, fast_en_q, fast_sel_q, half_en_q} <= RST_TIMER;
      end else begin
        if (wr_otg) begin
          pre_sel_q <= wdata[OTG_PRE_BIT];
          otg_lim_q <= clamp_limit(wdata[OTG_LIM_MSB:0]);
        end
        if (wr_timer) begin
          {top_sel_q, tri_en_q, pre_en_q, fast_en_q, fast_sel_q, half_en_q} <= wdata;
        end
      end
    end
  end

  // Charger control fields that only a register reset restores
  always_ff @(posedge clock) begin
    if (rst) begin
      auto_dis_q <= RST_CTRL[AUTO_DIS_BIT];
      force_dis_q <= RST_CTRL[FORCE_DIS_BIT];
      opt_en_q <= RST_CTRL[OPT_EN_BIT];
      hiz_q <= RST_CTRL[HIZ_BIT];
    end else if (clk_en) begin
      if (reg_reset_req) begin
        auto_dis_q <= RST_CTRL[AUTO_DIS_BIT];
        force_dis_q <= RST_CTRL[FORCE_DIS_BIT];
        opt_en_q <= RST_CTRL[OPT_EN_BIT];
        hiz_q <= RST_CTRL[HIZ_BIT];
      end else if (wr_ctrl) begin
        auto_dis_q <= wdata[AUTO_DIS_BIT];
        force_dis_q <= wdata[FORCE_DIS_BIT];
        opt_en_q <= wdata[OPT_EN_BIT];
        hiz_q <= wdata[HIZ_BIT];
      end else if (adapter_plug) begin
        hiz_q <= 1'b0;
      end
    end
  end

  // Charger control fields that the watchdog also restores
  always_ff @(posedge clock) begin
    if (rst) begin
      chg_en_q <= RST_CTRL[CHG_EN_BIT];
      term_q <= RST_CTRL[TERM_BIT];
    end else if (clk_en) begin
      if (reg_reset_req || watchdog_expired) begin
        chg_en_q <= RST_CTRL[CHG_EN_BIT];
        term_q <= RST_CTRL[TERM_BIT];
      end else if (wr_ctrl) begin
        chg_en_q <= wdata[CHG_EN_BIT];
        term_q <= wdata[TERM_BIT];
      end
    end
  end

  // Force-start: software sets, device clears, set wins
  always_ff @(posedge clock) begin
    if (rst) begin
      opt_force_q <= RST_CTRL[OPT_FORCE_BIT];
    end else if (clk_en) begin
      if (reg_reset_req || watchdog_expired) begin
        opt_force_q <= RST_CTRL[OPT_FORCE_BIT];
      end else if (wr_ctrl && wdata[OPT_FORCE_BIT]) begin
        opt_force_q <= 1'b1;
      end else if (optimizer_started) begin
        opt_force_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= READ_ZERO;
    end else if (clk_en && rd_en) begin
      unique case (addr)
        OFS_OTG: rdata <= {pre_sel_q, otg_lim_q};
        OFS_TIMER: rdata <= {top_sel_q, tri_en_q, pre_en_q, fast_en_q, fast_sel_q, half_en_q};
        OFS_CTRL: rdata <= {auto_dis_q, force_dis_q, chg_en_q, opt_en_q, opt_force_q, hiz_q,
                            term_q, 1'b0};
        default: rdata <= READ_ZERO;
      endcase
    end
  end

  // ----------------------------------------
  // Control outputs
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      otg_limit_ma <= '0;
      precharge_minutes <= '0;
      trickle_minutes <= '0;
      topoff_minutes <= '0;
      fast_minutes <= '0;
      topoff_active <= 1'b0;
      trickle_run <= 1'b0;
      precharge_run <= 1'b0;
      fast_run <= 1'b0;
      timer_half_rate <= 1'b0;
      timer_reset <= 1'b0;
      discharge_on <= 1'b0;
      charge_on <= 1'b0;
      term_allowed <= 1'b0;
      hiz_on <= 1'b0;
      optimizer_on <= 1'b0;
    end else if (clk_en) begin
      otg_limit_ma <= OTG_MA_W'(otg_lim_q * OTG_STEP_MA);
      precharge_minutes <= pre_sel_q ? PRE_SHORT_MIN : PRE_LONG_MIN;
      trickle_minutes <= TRICKLE_MIN;
      topoff_minutes <= topoff_decode(top_sel_q);
      topoff_active <= (top_sel_q != 2'h0);
      fast_minutes <= fast_decode(fast_sel_q);
      trickle_run <= tri_en_q;
      precharge_run <= pre_en_q;
      fast_run <= fast_en_q;
      timer_half_rate <= half_en_q && (pins_q[SY_DPM] || pins_q[SY_THERMAL]);
      timer_reset <= reg_reset_req;
      discharge_on <= force_dis_q || (auto_dis_q && pins_q[SY_OVP]);
      charge_on <= chg_en_q;
      term_allowed <= term_q;
      hiz_on <= hiz_q;
      optimizer_on <= opt_en_q;
    end
  end

  assign optimizer_run_req = opt_force_q && opt_en_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_otg_clamp_write: assert property (
    clk_en && wr_otg && !reg_reset_req && !watchdog_expired |=>
      otg_lim_q == clamp_limit($past(wdata[OTG_LIM_MSB:0])))
    else $error("otg limit not stored clamped");
  a_otg_min_hold: assert property (
    otg_lim_q >= OTG_LIM_MIN) else $error("otg limit below minimum");
  a_pre_minutes: assert property (
    clk_en |=> precharge_minutes == ($past(pre_sel_q) ? PRE_SHORT_MIN : PRE_LONG_MIN))
    else $error("pre-charge limit wrong");
  a_fast_default: assert property (
    clk_en && reg_reset_req ##1 clk_en |=> fast_minutes == FAST_12H_MIN)
    else $error("fast timer default not twelve hours");
  a_top_off_zero: assert property (
    clk_en && top_sel_q == 2'h0 |=> !topoff_active && topoff_minutes == TOP_OFF_MIN)
    else $error("top-off not disabled");
  a_half_rate_tie: assert property (
    clk_en && !half_en_q |=> !timer_half_rate) else $error("half rate without enable");
  a_discharge_force: assert property (
    clk_en && force_dis_q |=> discharge_on) else $error("forced discharge missing");
  a_discharge_auto: assert property (
    clk_en && !force_dis_q && !auto_dis_q |=> !discharge_on)
    else $error("discharge while auto disabled");
  a_force_gate_opt: assert property (
    !opt_en_q |-> !optimizer_run_req) else $error("force start not gated");
  a_force_clears: assert property (
    clk_en && opt_force_q && optimizer_started && !wr_ctrl |=> !opt_force_q)
    else $error("force start not cleared");
  a_force_set_only: assert property (
    clk_en && opt_force_q && wr_ctrl && !wdata[OPT_FORCE_BIT] && !optimizer_started
      && !reg_reset_req && !watchdog_expired |=> opt_force_q)
    else $error("software cleared force start");
  a_hiz_plug: assert property (
    clk_en && adapter_plug && !wr_ctrl && !reg_reset_req |=> !hiz_q)
    else $error("hiz not cleared on plug");
  a_wd_keeps_opt: assert property (
    clk_en && wd_hit && !wr_ctrl |=> $stable(opt_en_q) && $stable(auto_dis_q)
      && chg_en_q && term_q) else $error("watchdog restore wrong");
  a_reg_reset_all: assert property (
    clk_en && reg_reset_req |=> {auto_dis_q, force_dis_q, opt_en_q, hiz_q} == 4'h8
      && timer_reset) else $error("register reset incomplete");
  a_reserved_zero: assert property (
    clk_en && rd_en && addr == OFS_CTRL |=> rdata[0] == 1'b0)
    else $error("reserved bit not zero");

  c_plug_clears_hiz: cover property (hiz_q ##1 !hiz_q && !reg_reset_req);
  c_force_run: cover property (optimizer_run_req ##[1:20] !opt_force_q);
  c_half_rate: cover property (timer_half_rate);
  c_watchdog_hit: cover property (clk_en && wd_hit);

endmodule : charger_timer_control_regs

// *** tb/host_bus_model.sv ***
// Host-side model that issues register writes and reads into the bank
`timescale 1ns/1ps
module host_bus_model
  import charger_timer_pkg::*;
(
  input wire logic clock,
  output logic wr_en,
  output logic rd_en,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W-1:0] rdata
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end

  // --------------------------------------------------------------
  // Bus cycles
  // --------------------------------------------------------------
  // force bit only set
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clock);
    #1;
    wr_en = 1'b0;
    // Released lines show a changed value
    addr = ~addr;
    wdata = ~wdata;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    rd_en = 1'b1;
    addr = a;
    @(posedge clock);
    #1;
    rd_en = 1'b0;
    addr = ~addr;
    d = rdata;
  endtask : read_reg
endmodule : host_bus_model

// *** tb/charger_timer_control_regs_tb_top.sv ***
// Self-checking bench for the timer control register bank
`timescale 1ns/1ps
module charger_timer_control_regs_tb_top import charger_timer_pkg::*;;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic reg_reset_req = 1'b0;
  logic watchdog_expired = 1'b0;
  logic optimizer_started = 1'b0;
  logic adapter_plug_pin = 1'b0;
  logic dpm_pin = 1'b0;
  logic thermal_reg_pin = 1'b0;
  logic battery_ovp_pin = 1'b0;
  logic wr_en, rd_en;
  logic [7:0] addr, wdata, rdata;
  logic [OTG_MA_W-1:0] otg_limit_ma;
  logic [10:0] precharge_minutes, trickle_minutes, topoff_minutes, fast_minutes;
  logic topoff_active, trickle_run, precharge_run, fast_run, timer_half_rate, timer_reset;
  logic discharge_on, charge_on, term_allowed, hiz_on, optimizer_on, optimizer_run_req;
  logic [7:0] m_otg, m_timer, m_ctrl;
  logic [31:0] seed = 32'h00002DA3;
  logic [31:0] r;
  int error_cnt = 0;
  int n_checks = 0;
  logic [15:0] fast_tab [4] = '{16'h012C, 16'h01E0, 16'h02D0, 16'h05A0};
  logic [15:0] top_tab [4] = '{16'h0000, 16'h000F, 16'h001E, 16'h002D};
  logic [7:0] otg_tab [4] = '{8'h00, 8'h83, 8'h04, 8'hFF};
  logic [7:0] addr_tab [4] = '{OFS_OTG, OFS_TIMER, OFS_CTRL, 8'h10};

  always #4 clock = ~clock;

  charger_timer_control_regs u_charger_timer_control_regs (
    .clock(clock), .rst(rst), .clk_en(clk_en), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata(rdata), .reg_reset_req(reg_reset_req),
    .watchdog_expired(watchdog_expired), .optimizer_started(optimizer_started),
    .adapter_plug_pin(adapter_plug_pin), .dpm_pin(dpm_pin), .thermal_reg_pin(thermal_reg_pin),
    .battery_ovp_pin(battery_ovp_pin), .otg_limit_ma(otg_limit_ma),
    .precharge_minutes(precharge_minutes), .trickle_minutes(trickle_minutes),
    .topoff_minutes(topoff_minutes), .fast_minutes(fast_minutes), .topoff_active(topoff_active),
    .trickle_run(trickle_run), .precharge_run(precharge_run), .fast_run(fast_run),
    .timer_half_rate(timer_half_rate), .timer_reset(timer_reset), .discharge_on(discharge_on),
    .charge_on(charge_on), .term_allowed(term_allowed), .hiz_on(hiz_on),
    .optimizer_on(optimizer_on), .optimizer_run_req(optimizer_run_req));

  host_bus_model u_host_bus_model (
    .clock(clock), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata));

  // --------------------------------------------------------------
  // Model and checks
  // --------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_out

  task automatic mdefault();
    m_otg = RST_OTG;
    m_timer = RST_TIMER;
    m_ctrl = RST_CTRL;
  endtask : mdefault

  task automatic settle();
    repeat (8) @(posedge clock);
    #1;
  endtask : settle

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host_bus_model.write_reg(a, d);
    if (a == OFS_OTG) m_otg = (d[6:0] < OTG_LIM_MIN) ? {d[7], OTG_LIM_MIN} : d;
    else if (a == OFS_TIMER) m_timer = d;
    else if (a == OFS_CTRL) m_ctrl = (d & 8'hF6) | ((m_ctrl | d) & 8'h08);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host_bus_model.read_reg(a, d);
    chk_reg(d, exp);
  endtask : rd_chk

  // Sel 0 register reset, 1 watchdog, 2 optimizer run started
  task automatic pulse(input int sel);
    @(posedge clock);
    #1;
    reg_reset_req = (sel == 0);
    watchdog_expired = (sel == 1);
    optimizer_started = (sel == 2);
    @(posedge clock);
    #1;
    chk_out(16'(timer_reset), 16'(sel == 0));
    reg_reset_req = 1'b0;
    watchdog_expired = 1'b0;
    optimizer_started = 1'b0;
    if (sel == 0) mdefault();
    if (sel == 1) {m_otg, m_timer, m_ctrl} = {RST_OTG, RST_TIMER, (m_ctrl & 8'hD5) | 8'h22};
    if (sel == 2) m_ctrl[3] = 1'b0;
    settle();
  endtask : pulse

  task automatic chk_all();
    rd_chk(OFS_OTG, m_otg);
    rd_chk(OFS_TIMER, m_timer);
    rd_chk(OFS_CTRL, m_ctrl);
    rd_chk(8'h10, READ_ZERO);
    chk_out(16'(otg_limit_ma), 16'(m_otg[6:0]) * 16'h0028);
    chk_out(16'(precharge_minutes), m_otg[7] ? 16'h001E : 16'h0078);
    chk_out(16'(trickle_minutes), 16'h003C);
    chk_out(16'(topoff_minutes), top_tab[m_timer[7:6]]);
    chk_out(16'(topoff_active), 16'(m_timer[7:6] != 2'h0));
    chk_out(16'(fast_minutes), fast_tab[m_timer[2:1]]);
    chk_out(16'({trickle_run, precharge_run, fast_run}), 16'(m_timer[5:3]));
    chk_out(16'(timer_half_rate), 16'(m_timer[0] & (dpm_pin | thermal_reg_pin)));
    chk_out(16'(discharge_on), 16'(m_ctrl[6] | (m_ctrl[7] & battery_ovp_pin)));
    chk_out(16'({charge_on, optimizer_on, term_allowed}),
            16'({m_ctrl[5], m_ctrl[4], m_ctrl[1]}));
    chk_out(16'(hiz_on), 16'(m_ctrl[2]));
    chk_out(16'(optimizer_run_req), 16'(m_ctrl[3] & m_ctrl[4]));
  endtask : chk_all

  task automatic conclude();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  // --------------------------------------------------------------
  // Stimulus
  // --------------------------------------------------------------
  initial begin
    #(20000 * 8);
    error_cnt++;
    conclude();
  end

  initial begin
    mdefault();
    repeat (10) @(posedge clock);
    #1;
    rst = 1'b0;
    settle();
    chk_all();
    for (int i = 0; i < 4; i++) begin
      wr(OFS_OTG, otg_tab[i]);
      settle();
      chk_all();
    end
    // Frozen clock enable drops a write
    clk_en = 1'b0;
    u_host_bus_model.write_reg(OFS_TIMER, 8'h00);
    clk_en = 1'b1;
    settle();
    chk_all();
    wr(OFS_CTRL, 8'h0B);
    settle();
    chk_all();
    wr(OFS_CTRL, 8'h13);
    settle();
    chk_all();
    pulse(2);
    chk_all();
    repeat (40) begin
      r = rnd();
      dpm_pin = r[8];
      thermal_reg_pin = r[9];
      battery_ovp_pin = r[10];
      wr(addr_tab[r[1:0]], r[23:16]);
      settle();
      chk_all();
      if (m_ctrl[3] & m_ctrl[4]) pulse(2);
    end
    wr(OFS_OTG, 8'h85);
    wr(OFS_TIMER, 8'hC2);
    wr(OFS_CTRL, 8'h5D);
    settle();
    chk_all();
    pulse(1);
    chk_all();
    wr(OFS_CTRL, 8'h24);
    settle();
    adapter_plug_pin = 1'b1;
    m_ctrl[2] = 1'b0;
    settle();
    chk_all();
    adapter_plug_pin = 1'b0;
    for (int i = 0; i < 3; i++) wr(addr_tab[i], 8'hFF);
    settle();
    pulse(0);
    chk_all();
    conclude();
  end
endmodule : charger_timer_control_regs_tb_top
